//--- src/gotc_pkg.sv
// package: constants, types and register map of the gate output turn-off control
package gotc_pkg;

  // ----------------------------------------------------------------------
  // register map (word offsets, byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] GOTC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] GOTC_ADDR_TLA = 8'h04;
  localparam logic [7:0] GOTC_ADDR_TLB = 8'h08;
  localparam logic [7:0] GOTC_ADDR_SOFT = 8'h0C;
  localparam logic [7:0] GOTC_ADDR_STAT = 8'h10;

  // ----------------------------------------------------------------------
  // field layout of the control word
  // ----------------------------------------------------------------------
  localparam int GOTC_CTRL_NORM_LSB = 0;
  localparam int GOTC_CTRL_FAULT_LSB = 2;
  localparam int GOTC_CTRL_DLY_LSB = 8;
  localparam int GOTC_CTRL_RUN_BIT = 31;
  localparam int GOTC_STOP_W = 2;
  localparam int GOTC_DLY_W = 16;
  localparam int GOTC_TL_W = 16;
  localparam int GOTC_SOFT_W = 4;

  localparam logic [GOTC_STOP_W-1:0] GOTC_STOP_HARD = 2'h0;
  localparam logic [GOTC_STOP_W-1:0] GOTC_STOP_TWO = 2'h1;
  localparam logic [GOTC_STOP_W-1:0] GOTC_STOP_SOFT = 2'h2;

  localparam logic [31:0] GOTC_CTRL_RST = 32'h0000_0000;
  localparam logic [GOTC_TL_W-1:0] GOTC_TL_RST = 16'h0000;
  localparam logic [GOTC_SOFT_W-1:0] GOTC_SOFT_RST = 4'h8;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int GOTC_CLK_MHZ = 250;
  localparam int GOTC_PROP_NS = 40;
  localparam int GOTC_SATURATION_LOSS_DETECT_NS = 100;
  localparam logic [15:0] GOTC_PROP_CYC = 16'((GOTC_PROP_NS * GOTC_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] GOTC_SATURATION_LOSS_DETECT_CYC = 16'((GOTC_SATURATION_LOSS_DETECT_NS * GOTC_CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    GOTC_OFF = 3'b000,
    GOTC_WAIT = 3'b001,
    GOTC_ON = 3'b011,
    GOTC_RAMP_A = 3'b010,
    GOTC_PLAT = 3'b110,
    GOTC_RAMP_B = 3'b111,
    GOTC_SOFT = 3'b101,
    GOTC_LOCK = 3'b100
  } gotc_state_t;

  // drive commands toward the analog output stage
  typedef struct packed {
    logic src_en;
    logic sink_hard;
    logic ramp_a;
    logic plat_reg;
    logic ramp_b;
    logic soft_en;
    logic clamp;
  } gotc_drive_t;

  // two-level stop tuning: ramp A speed, plateau level, plateau time, ramp B speed
  typedef struct packed {
    logic [7:0] ramp_a_rate;
    logic [7:0] plat_level;
    logic [15:0] plat_time;
    logic [7:0] ramp_b_rate;
    logic [15:0] ramp_time;
  } gotc_tl_t;

endpackage : gotc_pkg

//--- src/gotc_core.sv
// gate output turn-off control with wishbone configuration port
// Notes on behaviour
// - supplies ok: pwm high sources, low sinks
// - ready/fault fall or primary loss: fault stop
// - secondary loss: sink clamps gate actively
// - turn-on connects source to secondary supply
// - normal stop: hard or two-level only
// - fault stop: hard, two-level or soft
// - programmable delay before fault stop
// - gate high flag while gate above threshold
// - fault stop completes, ignores pwm low
// - ramp A down then hold plateau
// - after plateau, ramp B to rail
// - two-level tuned by config A and B
// - two-level lengthens turn-on delay by plateau
// - plateau regulated closed loop at sink
// - pwm-low two-level starts at once, ramp A lengthened by propagation delay
// - saturation_loss_detect stop after detect delay plus delay
// - output-side fault: immediate or delayed
// - input-side fault: propagation plus delay
// - soft stop discharges via weak sink
// - soft current set by four-bit code
// - soft range scales with output strength
// - config read-only while running, except the run bit
`timescale 1ns/10ps
`default_nettype none
module gotc_core
  import gotc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pwm_i,
  input wire logic ready_check_pin_i,
  input wire logic fault_low_pin_i,
  input wire logic primary_supply_ok_i,
  input wire logic secondary_supply_ok_i,
  input wire logic saturation_loss_detect_i,
  input wire logic out_fault_i,
  input wire logic out_not_ready_i,
  input wire logic in_fault_i,
  input wire logic gate_above_thr_i,
  input wire logic plat_above_i,
  input wire logic [1:0] strength_i,
  output logic source_en_o,
  output logic sink_en_o,
  output logic sink_oe_o,
  output gotc_drive_t drive_o,
  output logic [GOTC_SOFT_W-1:0] soft_code_o,
  output logic [1:0] soft_range_o,
  output logic [7:0] ramp_rate_o,
  output logic [7:0] plat_level_o,
  output logic gate_high_flag_o,
  output logic fault_active_o
);

  // ----------------------------------------------------------------------
  // pin synchronisers: three stages, a change counts when 2nd and 3rd agree
  // ----------------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] filt_reg;

  assign raw_in = {pwm_i, ready_check_pin_i, fault_low_pin_i, primary_supply_ok_i,
                   secondary_supply_ok_i, saturation_loss_detect_i, gate_above_thr_i};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
          s3_reg[g] <= 1'b0;
          filt_reg[g] <= 1'b0;
        end else begin
          s1_reg[g] <= raw_in[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g]) begin
            filt_reg[g] <= s3_reg[g];
          end
        end
      end
    end
  endgenerate

  logic pwm_s, rdy_s, flt_s, vp_s, vs_s, saturation_loss_detect_s, gate_s;
  assign {pwm_s, rdy_s, flt_s, vp_s, vs_s, saturation_loss_detect_s, gate_s} = filt_reg;

  logic rdy_d_reg;
  logic flt_d_reg;
  logic vp_d_reg;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_d_reg <= 1'b0;
      flt_d_reg <= 1'b0;
      vp_d_reg <= 1'b0;
    end else begin
      rdy_d_reg <= rdy_s;
      flt_d_reg <= flt_s;
      vp_d_reg <= vp_s;
    end
  end

  // input-side stop causes, taken on the ready or fault pin falling edge, primary loss, or while in_fault_i is high
  logic in_side_evt;
  assign in_side_evt = (rdy_d_reg & ~rdy_s) | (flt_d_reg & ~flt_s) | (vp_d_reg & ~vp_s)
                       | in_fault_i;
  logic out_side_evt;
  assign out_side_evt = out_fault_i | out_not_ready_i;

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_reg;
  gotc_tl_t tl_reg;
  logic [GOTC_SOFT_W-1:0] soft_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;

  logic running;
  assign running = ctrl_reg[GOTC_CTRL_RUN_BIT];
  logic [GOTC_STOP_W-1:0] norm_stop_select;
  logic [GOTC_STOP_W-1:0] fault_stop_select;
  logic [GOTC_DLY_W-1:0] fault_stop_delay;
  assign norm_stop_select = ctrl_reg[GOTC_CTRL_NORM_LSB +: GOTC_STOP_W];
  assign fault_stop_select = ctrl_reg[GOTC_CTRL_FAULT_LSB +: GOTC_STOP_W];
  assign fault_stop_delay = ctrl_reg[GOTC_CTRL_DLY_LSB +: GOTC_DLY_W];

  logic wb_req;
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  // only the run bit may be written while running; tuning stays frozen
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= GOTC_CTRL_RST;
      tl_reg <= '0;
      soft_reg <= GOTC_SOFT_RST;
    end else if (wb_req && wb_we_i) begin
      unique case (wb_adr_i)
        GOTC_ADDR_CTRL: begin
          if (running) begin
            if (wb_sel_i[3]) begin
              ctrl_reg[GOTC_CTRL_RUN_BIT] <= wb_dat_i[GOTC_CTRL_RUN_BIT];
            end
          end else begin
            ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i);
          end
        end
        GOTC_ADDR_TLA: begin
          if (!running) begin
            {tl_reg.ramp_a_rate, tl_reg.plat_level, tl_reg.plat_time} <=
              merge({tl_reg.ramp_a_rate, tl_reg.plat_level, tl_reg.plat_time},
                    wb_dat_i, wb_sel_i);
          end
        end
        GOTC_ADDR_TLB: begin
          if (!running) begin
            {tl_reg.ramp_b_rate, tl_reg.ramp_time} <=
              24'(merge({8'h00, tl_reg.ramp_b_rate, tl_reg.ramp_time},
                        wb_dat_i, wb_sel_i));
          end
        end
        GOTC_ADDR_SOFT: begin
          if (!running && wb_sel_i[0]) begin
            soft_reg <= wb_dat_i[GOTC_SOFT_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  gotc_state_t st_reg;
  logic lock_cause_reg;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h0000_0000;
    end else if (wb_req) begin
      unique case (wb_adr_i)
        GOTC_ADDR_CTRL: rdat_reg <= ctrl_reg;
        GOTC_ADDR_TLA: rdat_reg <= {tl_reg.ramp_a_rate, tl_reg.plat_level, tl_reg.plat_time};
        GOTC_ADDR_TLB: rdat_reg <= {8'h00, tl_reg.ramp_b_rate, tl_reg.ramp_time};
        GOTC_ADDR_SOFT: rdat_reg <= {28'h000_0000, soft_reg};
        GOTC_ADDR_STAT: rdat_reg <= {24'h00_0000, 1'b0, st_reg, vs_s, vp_s,
                                     fault_active_o, gate_high_flag_o};
        default: rdat_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ----------------------------------------------------------------------
  // turn-off sequencer
  // ----------------------------------------------------------------------
  logic [GOTC_STOP_W-1:0] norm_eff;
  assign norm_eff = (norm_stop_select == GOTC_STOP_TWO) ? GOTC_STOP_TWO
                                                         : GOTC_STOP_HARD;
  logic fault_reg;
  logic [GOTC_STOP_W-1:0] style_reg;
  logic [GOTC_DLY_W+1:0] cnt_reg;
  logic cnt_zero;
  assign cnt_zero = (cnt_reg == '0);
  logic fault_start;
  logic [GOTC_DLY_W+1:0] fault_wait;

  // saturation_loss_detect adds its own detect delay, input-side causes add propagation delay
  always_comb begin
    fault_start = 1'b0;
    fault_wait = '0;
    if (saturation_loss_detect_s) begin
      fault_start = 1'b1;
      fault_wait = (GOTC_DLY_W+2)'(GOTC_SATURATION_LOSS_DETECT_CYC) + (GOTC_DLY_W+2)'(fault_stop_delay);
    end else if (in_side_evt) begin
      fault_start = 1'b1;
      fault_wait = (GOTC_DLY_W+2)'(GOTC_PROP_CYC) + (GOTC_DLY_W+2)'(fault_stop_delay);
    end else if (out_side_evt) begin
      fault_start = 1'b1;
      fault_wait = (GOTC_DLY_W+2)'(fault_stop_delay);
    end
  end

  logic pwm_on_ok;
  assign pwm_on_ok = pwm_s & rdy_s & flt_s & vp_s & ~out_side_evt & ~in_fault_i;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= GOTC_OFF;
      cnt_reg <= '0;
      fault_reg <= 1'b0;
      style_reg <= GOTC_STOP_HARD;
      lock_cause_reg <= 1'b0;
    end else if (!vs_s || !running) begin
      st_reg <= GOTC_OFF;
      cnt_reg <= '0;
      fault_reg <= 1'b0;
    end else if (fault_start && !fault_reg && st_reg != GOTC_LOCK) begin
      // fault wins over any normal stop in progress
      fault_reg <= 1'b1;
      style_reg <= fault_stop_select;
      // only a conducting gate is held through the delay; otherwise source would pulse on
      st_reg <= (st_reg == GOTC_ON) ? GOTC_WAIT : GOTC_LOCK;
      cnt_reg <= fault_wait;
    end else begin
      unique case (st_reg)
        GOTC_OFF: begin
          if (pwm_on_ok) begin
            st_reg <= GOTC_WAIT;
            cnt_reg <= (norm_eff == GOTC_STOP_TWO)
                       ? (GOTC_DLY_W+2)'(GOTC_PROP_CYC) + (GOTC_DLY_W+2)'(tl_reg.plat_time)
                       : (GOTC_DLY_W+2)'(GOTC_PROP_CYC);
          end
        end
        GOTC_WAIT: begin
          if (!cnt_zero) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else if (fault_reg) begin
            cnt_reg <= (GOTC_DLY_W+2)'(tl_reg.ramp_time);
            unique case (style_reg)
              GOTC_STOP_TWO: st_reg <= GOTC_RAMP_A;
              GOTC_STOP_SOFT: st_reg <= GOTC_SOFT;
              default: st_reg <= GOTC_LOCK;
            endcase
          end else if (!pwm_s) begin
            st_reg <= GOTC_OFF;
          end else begin
            st_reg <= GOTC_ON;
          end
        end
        GOTC_ON: begin
          if (!pwm_s) begin
            style_reg <= norm_eff;
            if (norm_eff == GOTC_STOP_TWO) begin
              st_reg <= GOTC_RAMP_A;
              cnt_reg <= (GOTC_DLY_W+2)'(tl_reg.ramp_time) + (GOTC_DLY_W+2)'(GOTC_PROP_CYC);
            end else begin
              st_reg <= GOTC_OFF;
            end
          end
        end
        GOTC_RAMP_A: begin
          if (!cnt_zero) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            st_reg <= GOTC_PLAT;
            cnt_reg <= (GOTC_DLY_W+2)'(tl_reg.plat_time);
          end
        end
        GOTC_PLAT: begin
          if (!cnt_zero) begin
            cnt_reg <= cnt_reg - 1'b1;
          end else begin
            st_reg <= GOTC_RAMP_B;
            cnt_reg <= (GOTC_DLY_W+2)'(tl_reg.ramp_time);
          end
        end
        GOTC_RAMP_B: begin
          if (!gate_s || cnt_zero) begin
            st_reg <= fault_reg ? GOTC_LOCK : GOTC_OFF;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        GOTC_SOFT: begin
          if (!gate_s) begin
            st_reg <= GOTC_LOCK;
          end
        end
        GOTC_LOCK: begin
          // stays off until ready, fault pin and supply return, no out-side, saturation_loss_detect or in_fault_i cause remains and pwm is low
          if (rdy_s && flt_s && vp_s && !pwm_s && !out_side_evt && !saturation_loss_detect_s && !in_fault_i) begin
            st_reg <= GOTC_OFF;
            fault_reg <= 1'b0;
            lock_cause_reg <= 1'b0;
          end else begin
            lock_cause_reg <= 1'b1;
          end
        end
        default: st_reg <= GOTC_LOCK;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // output stage drive
  // ----------------------------------------------------------------------
  gotc_drive_t drv;
  always_comb begin
    drv = '0;
    if (!vs_s) begin
      drv.clamp = 1'b1;
    end else begin
      unique case (st_reg)
        GOTC_ON: drv.src_en = 1'b1;
        GOTC_WAIT: begin
          drv.src_en = fault_reg;
          drv.sink_hard = ~fault_reg;
        end
        GOTC_RAMP_A: drv.ramp_a = 1'b1;
        GOTC_PLAT: drv.plat_reg = 1'b1;
        GOTC_RAMP_B: drv.ramp_b = 1'b1;
        GOTC_SOFT: drv.soft_en = 1'b1;
        default: drv.sink_hard = 1'b1;
      endcase
    end
  end

  logic src_q_reg;
  logic sink_q_reg;
  gotc_drive_t drv_reg;
  logic [7:0] rate_reg;
  logic ghf_reg;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drv_reg <= '0;
      src_q_reg <= 1'b0;
      sink_q_reg <= 1'b1;
      rate_reg <= 8'h00;
      ghf_reg <= 1'b0;
    end else begin
      drv_reg <= drv;
      src_q_reg <= drv.src_en;
      // plateau closed loop: sink only while the gate sits above the plateau
      sink_q_reg <= drv.sink_hard | drv.clamp | drv.ramp_a | drv.ramp_b | drv.soft_en
                    | (drv.plat_reg & plat_above_i);
      rate_reg <= drv.ramp_b ? tl_reg.ramp_b_rate : tl_reg.ramp_a_rate;
      ghf_reg <= gate_s;
    end
  end

  assign source_en_o = src_q_reg;
  assign sink_en_o = sink_q_reg;
  assign sink_oe_o = sink_q_reg;
  assign drive_o = drv_reg;
  assign soft_code_o = soft_reg;
  assign soft_range_o = strength_i;
  assign ramp_rate_o = rate_reg;
  assign plat_level_o = tl_reg.plat_level;
  assign gate_high_flag_o = ghf_reg;
  assign fault_active_o = fault_reg | lock_cause_reg;

endmodule : gotc_core
`default_nettype wire

//--- test/gotc_core_monitor.sv
// assertion checker bound to the gate output turn-off control
`timescale 1ns/10ps
`default_nettype none
module gotc_core_monitor
  import gotc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic pwm_i,
  input wire logic secondary_supply_ok_i,
  input wire logic gate_above_thr_i,
  input wire logic [1:0] strength_i,
  input wire logic source_en_o,
  input wire logic sink_en_o,
  input wire gotc_drive_t drive_o,
  input wire logic [1:0] soft_range_o,
  input wire logic gate_high_flag_o,
  input wire logic fault_active_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  chk_drive_excl: assert property (!(source_en_o && sink_en_o))
    else $error("source and sink both on");
  chk_sec_clamp: assert property (!secondary_supply_ok_i [*8] |-> sink_en_o && drive_o.clamp)
    else $error("no clamp on secondary loss");
  chk_fault_lock: assert property (fault_active_o && sink_en_o |=> !source_en_o)
    else $error("source on during fault stop");
  chk_flag_high: assert property (gate_above_thr_i [*8] |-> gate_high_flag_o)
    else $error("gate flag low with gate high");
  chk_flag_low: assert property (!gate_above_thr_i [*8] |-> !gate_high_flag_o)
    else $error("gate flag high with gate low");
  chk_soft_fault: assert property (drive_o.soft_en |-> fault_active_o)
    else $error("soft stop outside fault");
  chk_on_delay: assert property ($rose(source_en_o) |-> pwm_i && $past(pwm_i, 12))
    else $error("turn-on too early");
  chk_range_pass: assert property (soft_range_o == strength_i)
    else $error("soft range mismatch");
  cover property (drive_o.soft_en);
  cover property (drive_o.plat_reg);
  cover property ($rose(fault_active_o));
endmodule : gotc_core_monitor
bind gotc_core gotc_core_monitor u_gotc_core_monitor (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pwm_i(pwm_i),
  .secondary_supply_ok_i(secondary_supply_ok_i), .gate_above_thr_i(gate_above_thr_i),
  .strength_i(strength_i), .source_en_o(source_en_o), .sink_en_o(sink_en_o),
  .drive_o(drive_o), .soft_range_o(soft_range_o), .gate_high_flag_o(gate_high_flag_o),
  .fault_active_o(fault_active_o));
`default_nettype wire

//--- test/gotc_gate_model.sv
// behavioural model of the external power switch gate
`timescale 1ns/10ps
`default_nettype none
module gotc_gate_model
  import gotc_pkg::*;
(
  input wire logic clk_i,
  input wire logic source_en_i,
  input wire logic sink_en_i,
  input wire gotc_drive_t drive_i,
  input wire logic [7:0] plat_level_i,
  output logic gate_above_thr_o,
  output logic plat_above_o
);
  // gate level in 0.1 V steps above the negative rail, 200 is the positive rail
  int level = 0;
  always @(posedge clk_i) begin
    if (drive_i.ramp_a || drive_i.ramp_b || drive_i.soft_en)
      level <= (level > 2) ? level - 2 : 0;
    else if (drive_i.plat_reg)
      level <= plat_above_o ? level - 1 : level + 1;
    else if (sink_en_i || drive_i.clamp)
      level <= (level > 40) ? level - 40 : 0;
    else if (source_en_i)
      level <= (level < 160) ? level + 40 : 200;
  end
  assign gate_above_thr_o = (level > 20);
  assign plat_above_o = (level > int'(plat_level_i));
endmodule : gotc_gate_model
`default_nettype wire

//--- test/gotc_core_tb.sv
// self-checking testbench of the gate output turn-off control
`timescale 1ns/10ps
`default_nettype none
module gotc_core_tb
  import gotc_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, pwm_i = 1'b0;
  logic rdy = 1'b1, flt = 1'b1, pri = 1'b1, sec = 1'b1;
  logic sat = 1'b0, ofl = 1'b0, onr = 1'b0, ifl = 1'b0;
  logic [1:0] strength = 2'h0, srange;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, src, snk, soe, gflag, fact, g_thr, g_plat;
  gotc_drive_t drv;
  logic [3:0] scode, code;
  logic [7:0] rrate, plev, rate_a = 8'h00, lfsr = 8'h11;
  logic [31:0] rd_q[$];
  logic seen_soft = 1'b0;
  int error_cnt = 0, n_tests = 0, plat_cnt = 0, n, d, p;
  int base[7] = '{10, 10, 10, 25, 0, 0, 10};
  always #2 core_clk_i = ~core_clk_i;
  gotc_core u_gotc_core (.core_clk_i(core_clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_i(pwm_i),
    .ready_check_pin_i(rdy), .fault_low_pin_i(flt), .primary_supply_ok_i(pri),
    .secondary_supply_ok_i(sec), .saturation_loss_detect_i(sat), .out_fault_i(ofl),
    .out_not_ready_i(onr), .in_fault_i(ifl), .gate_above_thr_i(g_thr),
    .plat_above_i(g_plat), .strength_i(strength), .source_en_o(src), .sink_en_o(snk),
    .sink_oe_o(soe), .drive_o(drv), .soft_code_o(scode), .soft_range_o(srange),
    .ramp_rate_o(rrate), .plat_level_o(plev), .gate_high_flag_o(gflag), .fault_active_o(fact));
  gotc_gate_model u_gotc_gate_model (.clk_i(core_clk_i), .source_en_i(src), .sink_en_i(snk),
    .drive_i(drv), .plat_level_i(plev), .gate_above_thr_o(g_thr), .plat_above_o(g_plat));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next
  task automatic give_verdict();
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("Error at %0t: got %0h expected %0h to %0h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] dat,
                         input logic [3:0] sel);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk_i);
    if (i == 20) begin
      error_cnt++;
      give_verdict();
    end
  endtask : wb_xfer
  task automatic wb_rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    wb_xfer(1'b0, a, 32'h0000_0000, 4'hF);
  endtask : wb_rd
  // run is cleared first, since only the run bit is writable while it is set
  task automatic set_mode(input logic [31:0] ctrl);
    wb_xfer(1'b1, GOTC_ADDR_CTRL, 32'h0000_0000, 4'h8);
    wb_xfer(1'b1, GOTC_ADDR_CTRL, ctrl | 32'h8000_0000, 4'hF);
  endtask : set_mode
  task automatic wait_sig(input int which, input logic v, output int k);
    logic s;
    for (k = 0; k < 1000; k++) begin
      @(posedge core_clk_i);
      s = (which == 0) ? src : (which == 1) ? snk : (which == 2) ? fact : drv.ramp_b;
      if (s === v) break;
    end
    if (k == 1000) begin
      error_cnt++;
      give_verdict();
    end
  endtask : wait_sig
  // ---------------------------------------------------------------
  // result watcher
  // ---------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk(wb_dat_o, (rd_q.size() > 0) ? rd_q.pop_front() : 32'hDEAD_BEEF);
    if (drv.soft_en === 1'b1) seen_soft <= 1'b1;
    if (drv.plat_reg === 1'b1) plat_cnt <= plat_cnt + 1;
    if (drv.ramp_a === 1'b1) rate_a <= rrate;
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    strength <= lfsr[1:0];
    @(posedge core_clk_i);
    wb_rd(GOTC_ADDR_CTRL, GOTC_CTRL_RST);
    wb_rd(GOTC_ADDR_TLA, 32'h0000_0000);
    wb_rd(GOTC_ADDR_TLB, 32'h0000_0000);
    wb_rd(GOTC_ADDR_SOFT, 32'(GOTC_SOFT_RST));
    wb_rd(8'h14, 32'h0000_0000);
    lfsr = lfsr_next(lfsr);
    code = lfsr[3:0];
    p = 20 + int'(lfsr);
    wb_xfer(1'b1, GOTC_ADDR_SOFT, {28'h0, code}, 4'h1);
    wb_xfer(1'b1, GOTC_ADDR_TLA, {16'h1150, 16'(p)}, 4'hF);
    wb_xfer(1'b1, GOTC_ADDR_TLB, 32'h0022_003C, 4'hF);
    set_mode(32'h0000_0000);
    wb_xfer(1'b1, GOTC_ADDR_SOFT, {28'h0, ~code}, 4'h1);
    wb_rd(GOTC_ADDR_SOFT, {28'h0, code});
    chk(32'(scode), 32'(code));
    pwm_i <= 1'b1;
    wait_sig(0, 1'b1, n);
    chk_rng(n, 10, 20);
    chk(32'(snk), 32'h0);
    pwm_i <= 1'b0;
    wait_sig(1, 1'b1, n);
    chk_rng(n, 1, 8);
    chk(32'(src), 32'h0);
    set_mode(32'h0000_0001);
    pwm_i <= 1'b1;
    wait_sig(0, 1'b1, n);
    chk_rng(n, 10 + p, 20 + p);
    plat_cnt = 0;
    pwm_i <= 1'b0;
    wait_sig(3, 1'b1, n);
    chk_rng(plat_cnt, p, p + 1);
    chk(32'(rate_a), 32'h11);
    chk(32'(plev), 32'h50);
    @(posedge core_clk_i);
    chk(32'(rrate), 32'h22);
    chk(32'(gflag), 32'h1);
    wait_sig(1, 1'b1, n);
    set_mode(32'h0000_0002);
    seen_soft = 1'b0;
    pwm_i <= 1'b1;
    wait_sig(0, 1'b1, n);
    pwm_i <= 1'b0;
    wait_sig(1, 1'b1, n);
    chk(32'(seen_soft), 32'h0);
    for (int c = 0; c < 7; c++) begin
      lfsr = lfsr_next(lfsr);
      d = 4 + int'(lfsr[3:0]);
      set_mode({8'h00, 16'(d), 4'h0, 2'(c % 4), 2'h0});
      pwm_i <= 1'b1;
      wait_sig(0, 1'b1, n);
      seen_soft = 1'b0;
      case (c)
        0: flt <= 1'b0;
        1: rdy <= 1'b0;
        2: pri <= 1'b0;
        3: sat <= 1'b1;
        4: ofl <= 1'b1;
        5: onr <= 1'b1;
        default: ifl <= 1'b1;
      endcase
      @(posedge core_clk_i);
      // command low arrives while the fault stop is still delayed
      pwm_i <= 1'b0;
      wait_sig(0, 1'b0, n);
      chk_rng(n + 2, base[c] + d, base[c] + d + 12);
      chk(32'(fact), 32'h1);
      wait_sig(1, 1'b1, n);
      chk(32'(seen_soft), 32'(c % 4 == 2));
      pwm_i <= 1'b1;
      repeat (20) @(posedge core_clk_i);
      chk(32'(src), 32'h0);
      {flt, rdy, pri, sat, ofl, onr, ifl} <= 7'b1110000;
      pwm_i <= 1'b0;
      wait_sig(2, 1'b0, n);
      chk(32'(snk), 32'h1);
    end
    set_mode(32'h0000_0000);
    pwm_i <= 1'b1;
    wait_sig(0, 1'b1, n);
    sec <= 1'b0;
    wait_sig(1, 1'b1, n);
    chk_rng(n, 1, 10);
    repeat (8) @(posedge core_clk_i);
    chk(32'(drv.clamp), 32'h1);
    chk(32'(soe), 32'h1);
    sec <= 1'b1;
    pwm_i <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    chk(32'(gflag), 32'h0);
    give_verdict();
  end
endmodule : gotc_core_tb
`default_nettype wire
